// ### rtl/pllw_word_two.v
// second pll configuration word: serial load, field decode, shared pin role
//
// What this block does
// RULE1: [RULE1] store a received word only when bits 1:0 hold this word's select code
// RULE2: [RULE2] bit 2 sets pump direction, 0 positive and 1 negative; resets to 0
// RULE3: [RULE3] bit 3 set forces pump output to mid supply; resets to 0
// RULE4: [RULE4] bits 7:4 are pump current setting, reset value binary 1010
// RULE5: [RULE5] bits 9:8 are detector pulse width, reset value zero
// RULE6: [RULE6] bits 12:10 select feedback mux, reset value binary 101
// RULE7: [RULE7] five 3-bit pair source selects at bits 13..27, each resets to 101
// RULE8: [RULE8] bit 28 low puts outputs to sleep; resets to 1
// RULE9: [RULE9] bit 29 gives shared pin role, 0 divider reset, 1 pump hold
// RULE10: [RULE10] bit 30 low resets all dividers like the reset pin; resets to 1
// RULE11: [RULE11] bit 31 low tristates the pump like the hold pin; resets to 1
`timescale 1ns/1ps
`include "pllw_defs.vh"
module pllw_word_two
(
  input  wire                                     clk_sys_i,
  input  wire                                     rst_n_i,
  input  wire                                     cfg_clk_i,
  input  wire                                     cfg_data_i,
  input  wire                                     cfg_latch_i,
  input  wire                                     shared_pin_n_i,
  output reg  [`PLLW_WORD_W-1:0]                  pll_control_word_two_o,
  output reg                                      pump_direction_o,
  output reg                                      pump_midrail_preset_o,
  output reg  [`PLLW_CUR_MSB-`PLLW_CUR_LSB:0]     pump_current_o,
  output reg  [`PLLW_PFD_MSB-`PLLW_PFD_LSB:0]     detector_pulse_o,
  output reg  [`PLLW_FB_MSB-`PLLW_FB_LSB:0]       feedback_select_o,
  output reg  [`PLLW_PAIR_W-1:0]                  pair0_source_select_o,
  output reg  [`PLLW_PAIR_W-1:0]                  pair1_source_select_o,
  output reg  [`PLLW_PAIR_W-1:0]                  pair2_source_select_o,
  output reg  [`PLLW_PAIR_W-1:0]                  pair3_source_select_o,
  output reg  [`PLLW_PAIR_W-1:0]                  pair4_source_select_o,
  output reg                                      output_sleep_n_o,
  output reg                                      shared_pin_role_o,
  output reg                                      divider_reset_n_o,
  output reg                                      pump_tristate_o,
  output reg                                      word_loaded_o,
  output reg                                      word_ignored_o,
  output reg                                      frame_error_o
);

  // ************************************************************
  // pin synchronisation
  // ************************************************************

  wire [`PLLW_SYNC_W-1:0] pins_async;
  wire [`PLLW_SYNC_W-1:0] pins_sync;
  wire [`PLLW_SYNC_W-1:0] pins_rst_val;

  assign pins_async[`PLLW_SYNC_SCLK]  = cfg_clk_i;
  assign pins_async[`PLLW_SYNC_SDATA] = cfg_data_i;
  assign pins_async[`PLLW_SYNC_SLE]   = cfg_latch_i;
  assign pins_async[`PLLW_SYNC_PIN]   = shared_pin_n_i;
  // synchroniser starts at the idle levels, so no false edge follows reset
  assign pins_rst_val                 = `PLLW_SYNC_IDLE;

  pllw_sync
  #(
    .WIDTH (`PLLW_SYNC_W)
  )
  u_sync
  (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   (pins_async),
    .rst_val_i (pins_rst_val),
    .sync_o    (pins_sync)
  );

  wire sync_sclk;
  wire sync_sdata;
  wire sync_sle;
  wire sync_pin_n;

  assign sync_sclk  = pins_sync[`PLLW_SYNC_SCLK];
  assign sync_sdata = pins_sync[`PLLW_SYNC_SDATA];
  assign sync_sle   = pins_sync[`PLLW_SYNC_SLE];
  assign sync_pin_n = pins_sync[`PLLW_SYNC_PIN];

  // ************************************************************
  // serial receiver
  // ************************************************************

  wire [`PLLW_WORD_W-1:0] rx_word;
  wire                    rx_valid;
  wire                    rx_error;

  pllw_serial_rx u_rx
  (
    .clk_sys_i     (clk_sys_i),
    .rst_n_i       (rst_n_i),
    .sclk_i        (sync_sclk),
    .sdata_i       (sync_sdata),
    .sle_i         (sync_sle),
    .word_o        (rx_word),
    .word_valid_o  (rx_valid),
    .frame_error_o (rx_error)
  );

  // ************************************************************
  // word selection and storage
  // ************************************************************

  // true when the two low bits carry this word's select code
  function is_this_word;
    input [`PLLW_WORD_W-1:0] w;
    begin
      is_this_word = (w[`PLLW_SEL_MSB:`PLLW_SEL_LSB] == `PLLW_SEL_CODE);
    end
  endfunction

  reg  [`PLLW_WORD_W-1:0] word;
  reg  [`PLLW_WORD_W-1:0] next_word;
  wire                    accept;

  assign accept = rx_valid & is_this_word(rx_word); // [RULE1]

  always @*
  begin
    next_word = word;
    if (accept)
      next_word = rx_word; // [RULE1]
  end

  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      word <= `PLLW_RESET_VALUE; // [RULE2] [RULE3] [RULE4] [RULE5] [RULE6] [RULE7] [RULE8] [RULE9] [RULE10] [RULE11]
    else
      word <= next_word;
  end

  // ************************************************************
  // field decode
  // ************************************************************

  wire [`PLLW_PAIR_W-1:0] pair_sel [0:`PLLW_PAIR_N-1];

  genvar gi;
  generate
    for (gi = 0; gi < `PLLW_PAIR_N; gi = gi + 1)
    begin : g_pair
      // pair gi takes three bits starting at base plus three per pair
      assign pair_sel[gi] = word[`PLLW_PAIR_BASE + gi*`PLLW_PAIR_W +: `PLLW_PAIR_W]; // [RULE7]
    end
  endgenerate

  // ************************************************************
  // shared pin role and control merge
  // ************************************************************

  wire pin_active;
  wire role_hold;
  wire next_divider_reset_n;
  wire next_pump_tristate;

  assign pin_active = ~sync_pin_n;
  assign role_hold  = (word[`PLLW_BIT_ROLE] == `PLLW_ROLE_HOLD); // [RULE9]

  // software reset bit and pin in reset role both reset the dividers
  assign next_divider_reset_n = word[`PLLW_BIT_DIVRST_N] & ~(pin_active & ~role_hold); // [RULE9] [RULE10]

  // software hold bit and pin in hold role both tristate the pump
  assign next_pump_tristate = ~word[`PLLW_BIT_PUMP_ON] | (pin_active & role_hold); // [RULE9] [RULE11]

  // ************************************************************
  // power-up values of the field outputs
  // ************************************************************

  // each field powers up to its own slice of the reset word; the pump tristate control powers up to the inverse of bit 31
  localparam [`PLLW_WORD_W-1:0]              RST_WORD     = `PLLW_RESET_VALUE;
  localparam [0:0]                           RST_DIR      = RST_WORD[`PLLW_BIT_DIR];
  localparam [0:0]                           RST_PRESET   = RST_WORD[`PLLW_BIT_PRESET];
  localparam [`PLLW_CUR_MSB-`PLLW_CUR_LSB:0] RST_CUR      = RST_WORD[`PLLW_CUR_MSB:`PLLW_CUR_LSB];
  localparam [`PLLW_PFD_MSB-`PLLW_PFD_LSB:0] RST_PULSE    = RST_WORD[`PLLW_PFD_MSB:`PLLW_PFD_LSB];
  localparam [`PLLW_FB_MSB-`PLLW_FB_LSB:0]   RST_FB       = RST_WORD[`PLLW_FB_MSB:`PLLW_FB_LSB];
  localparam [`PLLW_PAIR_W-1:0]              RST_PAIR0    = RST_WORD[`PLLW_PAIR_BASE +: `PLLW_PAIR_W];
  localparam [`PLLW_PAIR_W-1:0]              RST_PAIR1    = RST_WORD[`PLLW_PAIR_BASE + `PLLW_PAIR_W +: `PLLW_PAIR_W];
  localparam [`PLLW_PAIR_W-1:0]              RST_PAIR2    = RST_WORD[`PLLW_PAIR_BASE + 2*`PLLW_PAIR_W +: `PLLW_PAIR_W];
  localparam [`PLLW_PAIR_W-1:0]              RST_PAIR3    = RST_WORD[`PLLW_PAIR_BASE + 3*`PLLW_PAIR_W +: `PLLW_PAIR_W];
  localparam [`PLLW_PAIR_W-1:0]              RST_PAIR4    = RST_WORD[`PLLW_PAIR_BASE + 4*`PLLW_PAIR_W +: `PLLW_PAIR_W];
  localparam [0:0]                           RST_SLEEP_N  = RST_WORD[`PLLW_BIT_SLEEP_N];
  localparam [0:0]                           RST_ROLE     = RST_WORD[`PLLW_BIT_ROLE];
  localparam [0:0]                           RST_DIVRST_N = RST_WORD[`PLLW_BIT_DIVRST_N];
  localparam [0:0]                           RST_TRISTATE = ~RST_WORD[`PLLW_BIT_PUMP_ON];

  // ************************************************************
  // next output values
  // ************************************************************

  wire                                   next_direction;
  wire                                   next_preset;
  wire [`PLLW_CUR_MSB-`PLLW_CUR_LSB:0]   next_current;
  wire [`PLLW_PFD_MSB-`PLLW_PFD_LSB:0]   next_pulse;
  wire [`PLLW_FB_MSB-`PLLW_FB_LSB:0]     next_feedback;
  wire [`PLLW_PAIR_W-1:0]                next_pair0;
  wire [`PLLW_PAIR_W-1:0]                next_pair1;
  wire [`PLLW_PAIR_W-1:0]                next_pair2;
  wire [`PLLW_PAIR_W-1:0]                next_pair3;
  wire [`PLLW_PAIR_W-1:0]                next_pair4;
  wire                                   next_sleep_n;
  wire                                   next_role;
  wire                                   next_loaded;
  wire                                   next_ignored;

  assign next_direction = word[`PLLW_BIT_DIR];               // [RULE2]
  assign next_preset    = word[`PLLW_BIT_PRESET];            // [RULE3]
  assign next_current   = word[`PLLW_CUR_MSB:`PLLW_CUR_LSB]; // [RULE4]
  assign next_pulse     = word[`PLLW_PFD_MSB:`PLLW_PFD_LSB]; // [RULE5]
  assign next_feedback  = word[`PLLW_FB_MSB:`PLLW_FB_LSB];   // [RULE6]
  assign next_pair0     = pair_sel[0];                       // [RULE7]
  assign next_pair1     = pair_sel[1];                       // [RULE7]
  assign next_pair2     = pair_sel[2];                       // [RULE7]
  assign next_pair3     = pair_sel[3];                       // [RULE7]
  assign next_pair4     = pair_sel[4];                       // [RULE7]
  assign next_sleep_n   = word[`PLLW_BIT_SLEEP_N];           // [RULE8]
  assign next_role      = word[`PLLW_BIT_ROLE];              // [RULE9]
  assign next_loaded    = accept;                            // [RULE1]
  assign next_ignored   = rx_valid & ~is_this_word(rx_word); // [RULE1]

  // ************************************************************
  // registered field outputs
  // ************************************************************

  // the loaded pulse leads the stored word on these outputs by one cycle
  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      pll_control_word_two_o <= RST_WORD;
      pump_direction_o       <= RST_DIR;
      pump_midrail_preset_o  <= RST_PRESET;
      pump_current_o         <= RST_CUR;
      detector_pulse_o       <= RST_PULSE;
      feedback_select_o      <= RST_FB;
      pair0_source_select_o  <= RST_PAIR0;
      pair1_source_select_o  <= RST_PAIR1;
      pair2_source_select_o  <= RST_PAIR2;
      pair3_source_select_o  <= RST_PAIR3;
      pair4_source_select_o  <= RST_PAIR4;
      output_sleep_n_o       <= RST_SLEEP_N;
      shared_pin_role_o      <= RST_ROLE;
    end
    else
    begin
      pll_control_word_two_o <= word;
      pump_direction_o       <= next_direction; // [RULE2]
      pump_midrail_preset_o  <= next_preset;    // [RULE3]
      pump_current_o         <= next_current;   // [RULE4]
      detector_pulse_o       <= next_pulse;     // [RULE5]
      feedback_select_o      <= next_feedback;  // [RULE6]
      pair0_source_select_o  <= next_pair0;     // [RULE7]
      pair1_source_select_o  <= next_pair1;
      pair2_source_select_o  <= next_pair2;
      pair3_source_select_o  <= next_pair3;
      pair4_source_select_o  <= next_pair4;
      output_sleep_n_o       <= next_sleep_n;   // [RULE8]
      shared_pin_role_o      <= next_role;      // [RULE9]
    end
  end

  // ************************************************************
  // registered pin controls
  // ************************************************************

  // soft bits and the shared pin merge here, so both act in the same cycle
  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      divider_reset_n_o <= RST_DIVRST_N;
      pump_tristate_o   <= RST_TRISTATE;
    end
    else
    begin
      divider_reset_n_o <= next_divider_reset_n; // [RULE10]
      pump_tristate_o   <= next_pump_tristate;   // [RULE11]
    end
  end

  // ************************************************************
  // frame outcome pulses
  // ************************************************************

  // one pulse per frame, never two of the three at once
  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      word_loaded_o  <= 1'b0;
      word_ignored_o <= 1'b0;
      frame_error_o  <= 1'b0;
    end
    else
    begin
      word_loaded_o  <= next_loaded;  // [RULE1]
      word_ignored_o <= next_ignored; // [RULE1]
      frame_error_o  <= rx_error;
    end
  end

endmodule

// ### common/pllw_defs.vh
// constants for the second pll configuration word and its serial loader
`ifndef PLLW_DEFS_VH
`define PLLW_DEFS_VH

`define PLLW_WORD_W        32
`define PLLW_CNT_W         6
`define PLLW_SYNC_W        4
`define PLLW_SEL_CODE      2'h2
`define PLLW_SEL_LSB       0
`define PLLW_SEL_MSB       1
`define PLLW_RESET_VALUE   32'hDB6D_B4A2
`define PLLW_BIT_DIR       2
`define PLLW_BIT_PRESET    3
`define PLLW_CUR_LSB       4
`define PLLW_CUR_MSB       7
`define PLLW_PFD_LSB       8
`define PLLW_PFD_MSB       9
`define PLLW_FB_LSB        10
`define PLLW_FB_MSB        12
`define PLLW_PAIR_BASE     13
`define PLLW_PAIR_W        3
`define PLLW_PAIR_N        5
`define PLLW_BIT_SLEEP_N   28
`define PLLW_BIT_ROLE      29
`define PLLW_BIT_DIVRST_N  30
`define PLLW_BIT_PUMP_ON   31
`define PLLW_ROLE_RESET    1'b0
`define PLLW_ROLE_HOLD     1'b1
`define PLLW_SYNC_SCLK     0
`define PLLW_SYNC_SDATA    1
`define PLLW_SYNC_SLE      2
`define PLLW_SYNC_PIN      3
`define PLLW_SYNC_IDLE     4'hC

`endif

// ### rtl/pllw_sync.v
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module pllw_sync
#(
  parameter WIDTH = 4
)
(
  input  wire             clk_sys_i,
  input  wire             rst_n_i,
  input  wire [WIDTH-1:0] async_i,
  input  wire [WIDTH-1:0] rst_val_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] stage_one;
  reg [WIDTH-1:0] stage_two;

  // the first stage feeds the second stage only; reset loads the idle levels
  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      stage_one <= rst_val_i;
      stage_two <= rst_val_i;
    end
    else
    begin
      stage_one <= async_i;
      stage_two <= stage_one;
    end
  end

  assign sync_o = stage_two;

endmodule

// ### rtl/pllw_serial_rx.v
// serial word receiver: shifts data on clock rises, frames on latch-enable rise
`timescale 1ns/1ps
`include "pllw_defs.vh"
module pllw_serial_rx
(
  input  wire                    clk_sys_i,
  input  wire                    rst_n_i,
  input  wire                    sclk_i,
  input  wire                    sdata_i,
  input  wire                    sle_i,
  output reg  [`PLLW_WORD_W-1:0] word_o,
  output reg                     word_valid_o,
  output reg                     frame_error_o
);

  reg                     sclk_d;
  reg                     sle_d;
  reg [`PLLW_WORD_W-1:0]  shift;
  reg [`PLLW_CNT_W-1:0]   count;
  wire                    sclk_rise;
  wire                    sle_rise;
  wire                    full;

  assign sclk_rise = sclk_i & ~sclk_d;
  assign sle_rise  = sle_i & ~sle_d;
  assign full      = (count == `PLLW_WORD_W);

  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      sclk_d        <= 1'b0;
      sle_d         <= 1'b1;
      shift         <= {`PLLW_WORD_W{1'b0}};
      count         <= {`PLLW_CNT_W{1'b0}};
      word_o        <= {`PLLW_WORD_W{1'b0}};
      word_valid_o  <= 1'b0;
      frame_error_o <= 1'b0;
    end
    else
    begin
      sclk_d        <= sclk_i;
      sle_d         <= sle_i;
      word_valid_o  <= 1'b0;
      frame_error_o <= 1'b0;
      if (sle_rise)
      begin
        // only a frame of exactly one word is passed on
        word_o        <= shift;
        word_valid_o  <= full;
        frame_error_o <= ~full;
        count         <= {`PLLW_CNT_W{1'b0}};
      end
      else if (!sle_i && sclk_rise)
      begin
        // msb first; bits beyond one word mark the frame bad
        shift <= {shift[`PLLW_WORD_W-2:0], sdata_i};
        if (count <= `PLLW_WORD_W)
          count <= count + 1'b1;
      end
    end
  end

endmodule

// ### test/pllw_host.sv
// host model that writes configuration words over the three-wire serial link
`timescale 1ns/1ps
module pllw_host
(
  input  wire logic clk_sys_i,
  output logic      cfg_clk_o,
  output logic      cfg_data_o,
  output logic      cfg_latch_o
);
  // ************************************************************
  // frame writer: every pin phase lasts four system cycles
  // ************************************************************
  initial
  begin
    cfg_clk_o = 1'b0;
    cfg_data_o = 1'b0;
    cfg_latch_o = 1'b1;
  end

  task automatic send(input logic [31:0] w, input int n);
    int i;
    @(negedge clk_sys_i);
    cfg_latch_o = 1'b0;
    for (i = n - 1; i >= 0; i--)
    begin
      repeat (4) @(negedge clk_sys_i);
      cfg_data_o = w[i % 32];
      repeat (4) @(negedge clk_sys_i);
      cfg_clk_o = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      cfg_clk_o = 1'b0;
    end
    repeat (4) @(negedge clk_sys_i);
    cfg_latch_o = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    // released data line no longer shows the last bit
    cfg_data_o = ~cfg_data_o;
  endtask
endmodule

// ### test/pllw_word_two_chk.sv
// assertions on the ports of the second pll configuration word
`timescale 1ns/1ps
module pllw_word_two_chk
(
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        shared_pin_n_i,
  input wire logic [31:0] pll_control_word_two_o,
  input wire logic        pump_direction_o,
  input wire logic        pump_midrail_preset_o,
  input wire logic [3:0]  pump_current_o,
  input wire logic [1:0]  detector_pulse_o,
  input wire logic [2:0]  feedback_select_o,
  input wire logic [2:0]  pair0_source_select_o,
  input wire logic [2:0]  pair1_source_select_o,
  input wire logic [2:0]  pair2_source_select_o,
  input wire logic [2:0]  pair3_source_select_o,
  input wire logic [2:0]  pair4_source_select_o,
  input wire logic        output_sleep_n_o,
  input wire logic        shared_pin_role_o,
  input wire logic        divider_reset_n_o,
  input wire logic        pump_tristate_o,
  input wire logic        word_loaded_o,
  input wire logic        word_ignored_o,
  input wire logic        frame_error_o
);
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  a_select_code: assert property (word_loaded_o |=> pll_control_word_two_o[1:0] == 2'b10)
    else $error("stored word carries a foreign select code");
  a_store_flag: assert property ($changed(pll_control_word_two_o) |-> $past(word_loaded_o))
    else $error("word changed without a load pulse");
  a_one_outcome: assert property (word_loaded_o |-> !word_ignored_o && !frame_error_o)
    else $error("more than one frame outcome");
  a_low_fields: assert property (word_loaded_o |=> {feedback_select_o, detector_pulse_o, pump_current_o,
    pump_midrail_preset_o, pump_direction_o} == pll_control_word_two_o[12:2]) else $error("low fields differ");
  a_pair_fields: assert property (word_loaded_o |=> {pair4_source_select_o, pair3_source_select_o,
    pair2_source_select_o, pair1_source_select_o, pair0_source_select_o} == pll_control_word_two_o[27:13])
    else $error("pair selects differ");
  a_top_fields: assert property (word_loaded_o |=> {shared_pin_role_o, output_sleep_n_o} == pll_control_word_two_o[29:28])
    else $error("sleep or role field differs");
  a_soft_divrst: assert property (word_loaded_o ##1 !pll_control_word_two_o[30] |-> !divider_reset_n_o)
    else $error("divider reset bit ignored");
  a_soft_hold: assert property (word_loaded_o ##1 !pll_control_word_two_o[31] |-> pump_tristate_o)
    else $error("pump hold bit ignored");
  a_pin_divrst: assert property ((!shared_pin_n_i && !shared_pin_role_o)[*5] |-> !divider_reset_n_o)
    else $error("shared pin did not reset dividers");
  a_pin_hold: assert property ((!shared_pin_n_i && shared_pin_role_o)[*5] |-> pump_tristate_o)
    else $error("shared pin did not hold pump");
  a_run_quiet: assert property ((shared_pin_n_i && pll_control_word_two_o[30])[*5] |-> divider_reset_n_o)
    else $error("dividers reset without cause");

  c_loaded: cover property (word_loaded_o);
  c_ignored: cover property (word_ignored_o);
  c_error: cover property (frame_error_o);
  c_hold: cover property (pump_tristate_o && shared_pin_n_i == 1'b0);
endmodule

bind pllw_word_two pllw_word_two_chk u_chk (.clk_sys_i, .rst_n_i, .shared_pin_n_i, .pll_control_word_two_o,
  .pump_direction_o, .pump_midrail_preset_o, .pump_current_o, .detector_pulse_o, .feedback_select_o,
  .pair0_source_select_o, .pair1_source_select_o, .pair2_source_select_o, .pair3_source_select_o,
  .pair4_source_select_o, .output_sleep_n_o, .shared_pin_role_o, .divider_reset_n_o, .pump_tristate_o,
  .word_loaded_o, .word_ignored_o, .frame_error_o);

// ### test/pllw_word_two_bench.sv
// self-checking bench for the second pll configuration word
`timescale 1ns/1ps
module pllw_word_two_bench;
  localparam logic [31:0] RST = 32'hDB6D_B4A2;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        shared_pin_n_i = 1'b1;
  wire         cfg_clk, cfg_data, cfg_latch, dir, pre, slp, role, dvn, trs, ld, ig, fe;
  wire  [31:0] word;
  wire  [3:0]  cur;
  wire  [1:0]  pls;
  wire  [2:0]  fb, p0, p1, p2, p3, p4;
  wire  [29:2] fields = {role, slp, p4, p3, p2, p1, p0, fb, pls, cur, pre, dir};
  logic [34:0] q[$];
  logic [34:0] e;
  logic [31:0] last = RST;
  logic [31:0] w;
  int          seed = 85;
  int          failures = 0;
  int          n_tests = 0;
  int          k;

  // ************************************************************
  // design, host and checking tasks
  // ************************************************************
  pllw_host host (.clk_sys_i(clk_sys_i), .cfg_clk_o(cfg_clk), .cfg_data_o(cfg_data), .cfg_latch_o(cfg_latch));
  pllw_word_two DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cfg_clk_i(cfg_clk), .cfg_data_i(cfg_data),
    .cfg_latch_i(cfg_latch), .shared_pin_n_i(shared_pin_n_i), .pll_control_word_two_o(word),
    .pump_direction_o(dir), .pump_midrail_preset_o(pre), .pump_current_o(cur), .detector_pulse_o(pls),
    .feedback_select_o(fb), .pair0_source_select_o(p0), .pair1_source_select_o(p1), .pair2_source_select_o(p2),
    .pair3_source_select_o(p3), .pair4_source_select_o(p4), .output_sleep_n_o(slp), .shared_pin_role_o(role),
    .divider_reset_n_o(dvn), .pump_tristate_o(trs), .word_loaded_o(ld), .word_ignored_o(ig), .frame_error_o(fe));

  always #50 clk_sys_i = ~clk_sys_i;

  task cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask

  // kind: loaded, ignored, error
  task load(input logic [31:0] v, input int n, input logic [2:0] kind);
    if (kind[2])
      last = v;
    q.push_back({kind, last});
    host.send(v, n);
    repeat (8) @(negedge clk_sys_i);
  endtask

  task pin(input logic [31:0] v, input logic d, input logic t);
    load(v, 32, 3'b100);
    shared_pin_n_i = 1'b0;
    repeat (6) @(negedge clk_sys_i);
    cmp("divider reset", {31'h0, d}, {31'h0, dvn});
    cmp("pump tristate", {31'h0, t}, {31'h0, trs});
    shared_pin_n_i = 1'b1;
    repeat (6) @(negedge clk_sys_i);
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(negedge clk_sys_i)
    if (rst_n_i && (ld || ig || fe))
    begin
      e = (q.size() > 0) ? q.pop_front() : '1;
      cmp("outcome", {29'h0, e[34:32]}, {29'h0, ld, ig, fe});
      // the stored word reaches the outputs one cycle after the pulse
      @(negedge clk_sys_i);
      cmp("word", e[31:0], word);
      cmp("fields", {4'h0, e[29:2]}, {4'h0, fields});
    end

  initial
  begin
    #1_000_000;
    failures++;
    complete_run();
  end

  initial
  begin
    repeat (6) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    cmp("reset word", RST, word);
    cmp("reset fields", {4'h0, RST[29:2]}, {4'h0, fields});
    cmp("reset pins", 32'h2, {30'h0, dvn, trs});
    $display("test reset done");
    for (k = 0; k < 6; k++)
    begin
      w = $random(seed);
      load({w[31:2], 2'b10}, 32, 3'b100);
    end
    load(32'h3FFF_FFFE, 32, 3'b100);
    cmp("soft pins", 32'h1, {30'h0, dvn, trs});
    $display("test load done");
    for (k = 0; k < 4; k++)
    begin
      w = $random(seed);
      if (k != 2)
        load({w[31:2], k[1:0]}, 32, 3'b010);
    end
    load(32'h8000_0002, 31, 3'b001);
    load(32'h8000_0002, 33, 3'b001);
    $display("test refuse done");
    pin(32'hC000_0002, 1'b0, 1'b0);
    pin(32'hE000_0002, 1'b1, 1'b1);
    $display("test pin done");
    complete_run();
  end
endmodule
